// [common/aaal_pkg.sv]
// shared constants and types of the address acceptance logic
`default_nettype none
package aaal_pkg;
  // ****************************************************
  // widths
  // ****************************************************
  localparam int ADDR_W = 13;
  localparam int APB_AW = 12;
  localparam int EV_W   = 4;

  // ****************************************************
  // register byte offsets
  // ****************************************************
  localparam logic [APB_AW-1:0] CTRL_OFS = 12'h000;
  localparam logic [APB_AW-1:0] MASK_OFS = 12'h004;
  localparam logic [APB_AW-1:0] STAT_OFS = 12'h008;
  localparam logic [APB_AW-1:0] LAST_OFS = 12'h00c;

  // ****************************************************
  // control fields and reset values
  // ****************************************************
  localparam int ANALYZE_BIT = 0;
  localparam int GAIN_LSB    = 1;
  localparam int GAIN_W      = 3;
  localparam int GROUP_LSB   = 4;
  localparam int GROUP_W     = 4;
  localparam int OFFS_LSB    = 8;
  localparam int OFFS_W      = 7;
  localparam logic [31:0] CTRL_WMASK = 32'h00007fff;
  localparam logic [31:0] CTRL_RST   = 32'h00000000;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;

  // last-address register fields
  localparam int LAST_STORE_BIT = 16;
  localparam int LAST_DT_BIT    = 17;

  // status event bits
  localparam int EV_STORED = 0;
  localparam int EV_UNDER  = 1;
  localparam int EV_OVER   = 2;
  localparam int EV_INHIB  = 3;

  // ****************************************************
  // ceiling and offset steps
  // ****************************************************
  localparam logic [ADDR_W:0]    GROUP_MIN     = 14'h0020;
  localparam logic [GROUP_W-1:0] GROUP_MAX_SEL = 4'h8;
  localparam int OFFS_STEP_SH = 6;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_MHZ          = 250;
  localparam int ACCEPT_DELAY_NS  = 1000;
  localparam int ACCEPT_DELAY_CYC = (ACCEPT_DELAY_NS * CLK_MHZ) / 1000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_PEAK, ST_INHIBIT, ST_RUNDOWN, ST_TEST, ST_HOLD
  } aaal_state_t;
endpackage
`default_nettype wire

// [src/aaal_accept_test.sv]
// offset subtraction and underflow / overflow tests
`timescale 1ns/1ps
`default_nettype none
module aaal_accept_test (
  input  wire logic [aaal_pkg::ADDR_W:0]    i_raw,
  input  wire logic [aaal_pkg::OFFS_W-1:0]  i_offset_steps,
  input  wire logic [aaal_pkg::GROUP_W-1:0] i_group_sel,
  output logic      [aaal_pkg::ADDR_W-1:0]  o_corrected,
  output logic      [aaal_pkg::ADDR_W:0]    o_ceiling,
  output logic                              o_underflow,
  output logic                              o_overflow
);
  import aaal_pkg::*;
  localparam int PAD = ADDR_W + 2 - OFFS_W - OFFS_STEP_SH;
  logic [ADDR_W+1:0]  offs;
  logic [ADDR_W+1:0]  diff;
  logic [GROUP_W-1:0] sel;

  always_comb begin
    // offset in 64-channel steps, a plain shift
    offs = {{PAD{1'b0}}, i_offset_steps, {OFFS_STEP_SH{1'b0}}}; // see RQ8
    diff = {1'b0, i_raw} - offs; // see RQ12
    // settings past the largest ceiling clamp to it
    sel = (i_group_sel > GROUP_MAX_SEL) ? GROUP_MAX_SEL : i_group_sel;
    o_ceiling = GROUP_MIN << sel; // see RQ2
    o_underflow = diff[ADDR_W+1]; // see RQ13
    o_corrected = diff[ADDR_W-1:0];
    // scaler overflow always rejects, whatever the offset
    o_overflow = !o_underflow &&
                 (i_raw[ADDR_W] || (diff[ADDR_W:0] >= o_ceiling)); // see RQ3
  end
endmodule
`default_nettype wire

// [src/aaal_delay_timer.sv]
// one-shot delay: done pulse so that action lands CYCLES edges after start
`timescale 1ns/1ps
`default_nettype none
module aaal_delay_timer #(
  parameter int CYCLES = aaal_pkg::ACCEPT_DELAY_CYC
) (
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  input  wire logic i_start,
  output logic      o_done
);
  import aaal_pkg::*;
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
  localparam logic [CW-1:0] ONE  = CW'(1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_done;

  always_comb begin
    next_cnt  = cnt;
    next_done = 1'b0;
    if (i_start) begin
      next_cnt = LOAD;
    end else if (cnt != '0) begin
      next_cnt  = cnt - ONE;
      next_done = (cnt == ONE);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cnt    <= '0;
      o_done <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      o_done <= next_done;
    end
  end
endmodule
`default_nettype wire

// [src/aaal_top.sv]
// converter address acceptance logic with apb registers
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RQ1 - reject addresses above the channel ceiling
// RQ2 - ceiling doubles from 32 to 8192
// RQ3 - overflow tested after conversion, on corrected address
// RQ4 - off setting holds converter in reset
// RQ5 - offset applied after conversion, timing unchanged
// RQ6 - upper threshold blocks conversion start
// RQ7 - both tests applied, failures discarded
// RQ8 - offset, gain, ceiling in binary steps
// RQ9 - memory side: address, store, clear, dead time
// RQ10 - store after 1 us, held until clear
// RQ11 - reject shows address 1 us, self clears
// RQ12 - subtract offset in 64 steps, negative underflows
// RQ13 - borrow is underflow, 13-bit compare; the code compares 14 bits of the difference with the ceiling
// RQ14 - dead time from start until address cleared
module aaal_top (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_reset,
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [aaal_pkg::APB_AW-1:0] i_paddr,
  input  wire logic [31:0]                 i_pwdata,
  output logic      [31:0]                 o_prdata,
  output logic                             o_pready,
  output logic                             o_pslverr,
  input  wire logic                        i_lower_threshold_gate,
  input  wire logic                        i_upper_threshold_gate,
  input  wire logic                        i_peak_detect,
  input  wire logic                        i_rundown_end,
  input  wire logic                        i_clear,
  output logic      [aaal_pkg::ADDR_W-1:0] o_address,
  output logic                             o_store,
  output logic                             o_dead_time_flag,
  output logic                             o_converter_reset,
  output logic      [aaal_pkg::GAIN_W-1:0] o_gain_select,
  output logic                             o_irq
);
  import aaal_pkg::*;
  localparam logic [ADDR_W:0] SCALER_ONE = 14'h0001;

  logic [31:0]       ctrl;
  logic [31:0]       next_ctrl;
  logic [EV_W-1:0]   mask;
  logic [EV_W-1:0]   next_mask;
  logic [EV_W-1:0]   status;
  logic [EV_W-1:0]   next_status;
  logic [EV_W-1:0]   events;
  logic [31:0]       next_prdata;
  logic              next_pready;
  logic              next_pslverr;
  logic              next_irq;
  logic              apb_done;
  aaal_state_t       state;
  aaal_state_t       next_state;
  logic [ADDR_W:0]   scaler;
  logic [ADDR_W:0]   next_scaler;
  logic [ADDR_W-1:0] next_address;
  logic              next_store;
  logic              next_dt;
  logic              lower_q;
  logic              analyze;
  logic              rundown_done;
  logic              timer_done;
  logic [ADDR_W-1:0] corrected;
  logic [ADDR_W:0]   ceiling;
  logic              underflow;
  logic              overflow;

  // ****************************************************
  // apb slave: setup, one wait cycle, then ready
  // ****************************************************
  assign apb_done = i_psel && i_penable && o_pready;

  always_comb begin
    next_ctrl    = ctrl;
    next_mask    = mask;
    next_status  = status;
    next_pready  = i_psel && i_penable && !o_pready;
    next_prdata  = 32'h00000000;
    next_pslverr = 1'b0;
    if (next_pready) begin
      case (i_paddr)
        CTRL_OFS: next_prdata = ctrl;
        MASK_OFS: next_prdata = {{(32-EV_W){1'b0}}, mask};
        STAT_OFS: next_prdata = {{(32-EV_W){1'b0}}, status};
        LAST_OFS: next_prdata = {14'h0000, o_dead_time_flag, o_store,
                                 3'h0, o_address};
        default:  next_pslverr = 1'b1;
      endcase
    end
    if (apb_done && i_pwrite && i_paddr == CTRL_OFS) begin
      next_ctrl = i_pwdata & CTRL_WMASK;
    end
    if (apb_done && i_pwrite && i_paddr == MASK_OFS) begin
      next_mask = i_pwdata[EV_W-1:0];
    end
    // only the bits that were returned are cleared; new events win
    if (apb_done && !i_pwrite && i_paddr == STAT_OFS) begin
      next_status = status & ~o_prdata[EV_W-1:0];
    end
    next_status = next_status | events;
    next_irq    = |(next_status & next_mask);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ctrl          <= CTRL_RST;
      mask          <= MASK_RST;
      status        <= '0;
      o_prdata      <= 32'h00000000;
      o_pready      <= 1'b0;
      o_pslverr     <= 1'b0;
      o_irq         <= 1'b0;
      o_gain_select <= CTRL_RST[GAIN_LSB +: GAIN_W];
    end else begin
      ctrl          <= next_ctrl;
      mask          <= next_mask;
      status        <= next_status;
      o_prdata      <= next_prdata;
      o_pready      <= next_pready;
      o_pslverr     <= next_pslverr;
      o_irq         <= next_irq;
      o_gain_select <= next_ctrl[GAIN_LSB +: GAIN_W]; // see RQ8
    end
  end

  // ****************************************************
  // acceptance tests and delay
  // ****************************************************
  aaal_accept_test aaal_accept_test_inst (
    .i_raw          (scaler),
    .i_offset_steps (ctrl[OFFS_LSB +: OFFS_W]),
    .i_group_sel    (ctrl[GROUP_LSB +: GROUP_W]),
    .o_corrected    (corrected),
    .o_ceiling      (ceiling),
    .o_underflow    (underflow),
    .o_overflow     (overflow)
  );

  assign analyze      = ctrl[ANALYZE_BIT];
  assign rundown_done = (state == ST_RUNDOWN) && i_rundown_end && analyze;

  aaal_delay_timer #(
    .CYCLES (ACCEPT_DELAY_CYC)
  ) aaal_delay_timer_inst (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_start   (rundown_done),
    .o_done    (timer_done)
  );

  // ****************************************************
  // conversion sequence
  // ****************************************************
  always_comb begin
    next_state   = state;
    next_scaler  = scaler;
    next_address = o_address;
    next_store   = o_store;
    events       = '0;
    unique case (state)
      ST_IDLE: begin
        if (i_lower_threshold_gate && !lower_q) begin
          next_state = ST_WAIT_PEAK;
        end
      end
      ST_WAIT_PEAK: begin
        if (i_upper_threshold_gate) begin
          next_state       = ST_INHIBIT; // see RQ6
          events[EV_INHIB] = 1'b1;
        end else if (!i_lower_threshold_gate) begin
          next_state = ST_IDLE;
        end else if (i_peak_detect) begin
          next_state  = ST_RUNDOWN;
          next_scaler = '0;
        end
      end
      ST_INHIBIT: begin
        // dead time lasts while the pulse stays above the lower level
        if (!i_lower_threshold_gate) begin
          next_state = ST_IDLE;
        end
      end
      ST_RUNDOWN: begin
        // scaler is independent of the offset setting
        if (i_rundown_end) begin
          next_state = ST_TEST; // see RQ5
        end else if (!scaler[ADDR_W]) begin
          next_scaler = scaler + SCALER_ONE;
        end
      end
      ST_TEST: begin
        next_address = corrected; // see RQ9
        if (timer_done) begin
          if (underflow || overflow) begin
            next_state       = ST_IDLE; // see RQ7
            next_address     = '0; // see RQ11
            events[EV_UNDER] = underflow;
            events[EV_OVER]  = overflow; // see RQ1
          end else begin
            next_state        = ST_HOLD;
            next_store        = 1'b1; // see RQ10
            events[EV_STORED] = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        if (i_clear) begin
          next_state   = ST_IDLE; // see RQ10
          next_store   = 1'b0;
          next_address = '0;
        end
      end
    endcase
    if (!analyze) begin
      next_state   = ST_IDLE; // see RQ4
      next_scaler  = '0;
      next_address = '0;
      next_store   = 1'b0;
      events       = '0;
    end
    next_dt = (next_state != ST_IDLE); // see RQ14
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state             <= ST_IDLE;
      scaler            <= '0;
      lower_q           <= 1'b0;
      o_address         <= '0;
      o_store           <= 1'b0;
      o_dead_time_flag  <= 1'b0;
      o_converter_reset <= 1'b1;
    end else begin
      state             <= next_state;
      scaler            <= next_scaler;
      lower_q           <= i_lower_threshold_gate;
      o_address         <= next_address;
      o_store           <= next_store;
      o_dead_time_flag  <= next_dt;
      o_converter_reset <= !analyze; // see RQ4
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);

  logic [ADDR_W+1:0] offs_chan;
  assign offs_chan = {2'b00, ctrl[OFFS_LSB +: OFFS_W], 6'h00};

  ovf_reject_a: assert property ( // see RQ1
    (state == ST_TEST) && timer_done && overflow && analyze |=> !o_store)
    else $error("overflowed address was stored");
  ceil_pow2_a: assert property ( // see RQ2
    $onehot(ceiling) && (ceiling >= GROUP_MIN) && (ceiling <= 14'h2000))
    else $error("ceiling not a power of two in range");
  store_ceiling_a: assert property ( // see RQ3
    $rose(o_store) |-> ({1'b0, o_address} < ceiling))
    else $error("stored address at or above ceiling");
  off_reset_a: assert property ( // see RQ4
    !analyze |=> (state == ST_IDLE) && o_converter_reset && !o_store)
    else $error("converter not held in reset when off");
  scaler_step_a: assert property ( // see RQ5
    (state == ST_RUNDOWN) && !i_rundown_end && !scaler[ADDR_W] && analyze
    |=> scaler == $past(scaler) + SCALER_ONE)
    else $error("scaler did not advance during rundown");
  upper_block_a: assert property ( // see RQ6
    (state == ST_WAIT_PEAK) && i_upper_threshold_gate |=> state != ST_RUNDOWN)
    else $error("conversion started above upper threshold");
  store_pass_a: assert property ( // see RQ7
    $rose(o_store) |-> $past(!underflow && !overflow && timer_done))
    else $error("store without passing both tests");
  test_span_a: assert property ( // see RQ10
    rundown_done |-> ##250 ((state == ST_TEST) && !o_store || !analyze))
    else $error("store decided before the delay");
  store_time_a: assert property ( // see RQ10
    rundown_done |-> ##251 (o_store || state == ST_IDLE || !analyze))
    else $error("no decision one microsecond after conversion");
  hold_a: assert property ( // see RQ10
    o_store && !i_clear && analyze |=> o_store && $stable(o_address))
    else $error("store or address dropped before clear");
  reject_a: assert property ( // see RQ11
    (state == ST_TEST) && timer_done && (underflow || overflow) && analyze
    |=> !o_store && (o_address == '0) && (state == ST_IDLE))
    else $error("rejected address not cleared internally");
  underflow_a: assert property ( // see RQ12
    (state == ST_TEST) |-> underflow == ({1'b0, scaler} < offs_chan))
    else $error("underflow test wrong");
  corrected_a: assert property ( // see RQ13
    (state == ST_TEST) && !underflow && !scaler[ADDR_W]
    |-> ({2'b00, corrected} + offs_chan) == {1'b0, scaler})
    else $error("corrected address wrong");
  dead_time_a: assert property ( // see RQ14
    o_dead_time_flag == (state != ST_IDLE))
    else $error("dead time flag out of step");
  dead_start_a: assert property ( // see RQ14
    (state == ST_IDLE) && i_lower_threshold_gate && !lower_q && analyze
    |=> o_dead_time_flag)
    else $error("dead time not raised at conversion start");
  set_wins_a: assert property (
    (events != '0) |=> (status & $past(events)) == $past(events))
    else $error("event lost on status clear");

  store_c: cover property ($rose(o_store) ##[1:20] i_clear);
  reject_c: cover property ((state == ST_TEST) && timer_done && underflow);
  inhibit_c: cover property (events[EV_INHIB]);
  irq_c: cover property ($rose(o_irq));
endmodule
`default_nettype wire

// [testbench/aaal_memory_model.sv]
// memory-side partner: takes stored addresses and returns a clear pulse
`timescale 1ns/1ps
`default_nettype none
module aaal_memory_model (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_reset,
  input  wire logic [aaal_pkg::ADDR_W-1:0] i_address,
  input  wire logic                        i_store,
  input  wire logic [7:0]                  i_delay,
  output logic                             o_clear,
  output logic      [aaal_pkg::ADDR_W-1:0] o_taken,
  output logic      [15:0]                 o_count
);
  import aaal_pkg::*;
  logic [7:0] wait_cnt;

  // answer after i_delay cycles, so both prompt and slow partners exist
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_clear  <= 1'b0;
      wait_cnt <= 8'h00;
      o_count  <= 16'h0000;
      o_taken  <= '0;
    end else if (o_clear === 1'b1) begin
      o_clear  <= 1'b0;
    end else if (i_store !== 1'b1) begin
      wait_cnt <= 8'h00;
    end else if (wait_cnt >= i_delay) begin
      o_clear  <= 1'b1;
      o_taken  <= i_address;
      o_count  <= o_count + 16'h0001;
      wait_cnt <= 8'h00;
    end else begin
      wait_cnt <= wait_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [testbench/aaal_top_bench.sv]
// self-checking bench of the address acceptance logic
`timescale 1ns/1ps
`default_nettype none
module aaal_top_bench;
  import aaal_pkg::*;
  logic              clk;
  logic              rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              lower;
  logic              upper;
  logic              peak;
  logic              rundown;
  logic              clear;
  logic [ADDR_W-1:0] address;
  logic              store;
  logic              dead;
  logic              conv_rst;
  logic [GAIN_W-1:0] gain;
  logic              irq;
  logic [7:0]        delay;
  logic [ADDR_W-1:0] taken;
  logic [ADDR_W-1:0] shown;
  logic [31:0]       q;
  logic              err;
  logic              ok;
  int                fails;
  int                compares;
  int                cal;
  int                lat;
  int                hold;

  aaal_top aaal_top_inst (
    .i_ref_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_lower_threshold_gate(lower), .i_upper_threshold_gate(upper),
    .i_peak_detect(peak), .i_rundown_end(rundown), .i_clear(clear),
    .o_address(address), .o_store(store), .o_dead_time_flag(dead),
    .o_converter_reset(conv_rst), .o_gain_select(gain), .o_irq(irq)
  );

  aaal_memory_model aaal_memory_model_inst (
    .i_ref_clk(clk), .i_reset(rst), .i_address(address), .i_store(store),
    .i_delay(delay), .o_clear(clear), .o_taken(taken), .o_count()
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************************
  // checking and bus tasks
  // ****************************************************
  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic hang(input string what);
    fails++;
    $display("FAIL %s expected done seen timeout", what);
    complete_run();
  endtask

  task automatic apb(input logic wr, input logic [APB_AW-1:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) hang("apb");
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [APB_AW-1:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, q, exp);
  endtask

  task automatic ctrl(input int sel, input int steps, input logic on);
    apb(1'b1, CTRL_OFS, 32'(on) | 32'(5 << GAIN_LSB) |
        32'(sel << GROUP_LSB) | 32'(steps << OFFS_LSB));
  endtask

  // ****************************************************
  // one analog pulse, n clocks of rundown
  // ****************************************************
  task automatic conv(input int n);
    @(posedge clk);
    lower <= 1'b1;
    @(posedge clk);
    peak <= 1'b1;
    @(posedge clk);
    peak <= 1'b0;
    repeat (n - 1) @(posedge clk);
    rundown <= 1'b1;
    @(posedge clk);
    rundown <= 1'b0;
    lower <= 1'b0;
    lat = 0;
    ok = 1'b0;
    hold = 0;
    while (1) begin
      @(posedge clk);
      lat++;
      if (lat == 5) shown = address;
      if (store === 1'b1) begin
        ok = 1'b1;
        break;
      end
      if (dead === 1'b0) break;
      if (lat > 1000) hang("decision");
    end
    while (ok && store === 1'b1) begin
      @(posedge clk);
      hold++;
      if (hold > 1000) hang("clear");
    end
  endtask

  task automatic run(input int raw, input logic exp_ok,
                     input logic [ADDR_W-1:0] exp_a);
    conv(raw - cal);
    check("accepted", 32'(ok), 32'(exp_ok));
    check("address", 32'(shown), 32'(exp_a));
    check("decision delay", 32'(lat), ACCEPT_DELAY_CYC + 1);
    check("dead after", 32'(dead), 32'h0);
    if (exp_ok) check("taken", 32'(taken), 32'(exp_a));
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, lower, upper, peak, rundown} = '0;
    paddr = '0;
    pwdata = '0;
    delay = 8'h02;
    {fails, compares, cal} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    check("converter reset", 32'(conv_rst), 32'h1);
    rdchk("ctrl reset", CTRL_OFS, CTRL_RST);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped", 32'(err), 32'h1);
    ctrl(8, 0, 1'b1);
    repeat (2) @(posedge clk);
    check("gain", 32'(gain), 32'h5);
    check("converter running", 32'(conv_rst), 32'h0);
    conv(100);
    cal = int'(shown) - 100;
    check("scaler origin", 32'(cal), 32'hffffffff);
    for (int s = 0; s <= 8; s++) begin
      ctrl(s, 0, 1'b1);
      run((32 << s) - 1, 1'b1, 13'((32 << s) - 1));
      run(32 << s, 1'b0, 13'(32 << s));
    end
    ctrl(9, 0, 1'b1);
    run(8191, 1'b1, 13'h1fff);
    check("irq masked", 32'(irq), 32'h0);
    rdchk("status sweep", STAT_OFS, 32'h5);
    apb(1'b1, MASK_OFS, 32'hf);
    rdchk("mask", MASK_OFS, 32'hf);
    ctrl(8, 1, 1'b1);
    run(100, 1'b1, 13'd36);
    check("irq raised", 32'(irq), 32'h1);
    rdchk("status stored", STAT_OFS, 32'h1);
    repeat (2) @(posedge clk);
    check("irq cleared", 32'(irq), 32'h0);
    ctrl(8, 2, 1'b1);
    run(128, 1'b1, 13'h0);
    run(127, 1'b0, 13'h1fff);
    rdchk("status under", STAT_OFS, 32'h3);
    delay <= 8'd40;
    ctrl(8, 0, 1'b1);
    conv(200 - cal);
    check("held for clear", 32'(hold > 40), 32'h1);
    delay <= 8'h02;
    @(posedge clk);
    lower <= 1'b1;
    @(posedge clk);
    upper <= 1'b1;
    repeat (10) @(posedge clk);
    check("inhibit dead", 32'(dead), 32'h1);
    check("inhibit store", 32'(store), 32'h0);
    rdchk("last inhibit", LAST_OFS, 32'h00020000);
    lower <= 1'b0;
    upper <= 1'b0;
    repeat (3) @(posedge clk);
    check("inhibit done", 32'(dead), 32'h0);
    rdchk("status inhibit", STAT_OFS, 32'h9);
    lower <= 1'b1;
    @(posedge clk);
    ctrl(8, 0, 1'b0);
    repeat (2) @(posedge clk);
    check("off reset", 32'(conv_rst), 32'h1);
    check("off dead", 32'(dead), 32'h0);
    lower <= 1'b0;
    complete_run();
  end

  initial begin
    repeat (90000) @(posedge clk);
    hang("run");
  end
endmodule
`default_nettype wire
